// ===== dfp_device.sv
`timescale 1ns/1ns
module dfp_device #(
    parameter logic [7:0] DEVICE_ID = 8'h5a,   // arbitrary value
    parameter logic [7:0] REVISION_ID = 8'h03  // arbitrary value
) (
    input wire logic core_clk_in,              // core clock
    input wire logic sys_rst_in,               // async reset, active high
    dfp_link_if.device link,                   // debug link pins
    input wire logic [7:0] prog_rd_data_in,    // byte returned on data reads
    input wire logic cmd_done_in,              // flash side ready for next command
    output logic prog_enabled_out,             // programming mode active
    output logic [7:0] flash_control_out,      // last value written to control
    output logic device_erase_out,             // pulse: whole device erase
    output logic page_erase_out,               // pulse: page erase
    output logic block_read_out,               // pulse: block read
    output logic block_write_out,              // pulse: block write
    output logic prog_data_wr_out,             // pulse: byte written to data reg
    output logic [7:0] prog_data_out,          // byte written to data reg
    output logic prog_data_rd_out              // pulse: data reg read by host
);
    typedef enum logic [2:0] {
        DS_IDLE,
        DS_OP,
        DS_DATA,
        DS_TURN,
        DS_REPLY
    } dfp_dev_phase_t;

    typedef enum logic [1:0] {
        UL_LOCKED,
        UL_FIRST,
        UL_OPEN
    } dfp_unlock_t;

    typedef struct packed {
        dfp_dev_phase_t st;
        logic [3:0] cnt;
        logic [1:0] op;
        logic [7:0] sh;
        logic [7:0] sel;
        logic [7:0] ctrl;
        dfp_unlock_t unlock;
        logic cmd_wait;
        logic clk_prev;
        logic drv;
        logic oe;
        logic erase_all;
        logic erase_page;
        logic blk_rd;
        logic blk_wr;
        logic wr_stb;
        logic rd_stb;
        logic [7:0] wdata;
    } dfp_dev_state_t;

    dfp_dev_state_t r;
    dfp_dev_state_t next_r;
    logic s_clk;
    logic s_data;
    logic rise;
    logic fall;

    // ------------------------------------------------------------
    // pin sampling
    // ------------------------------------------------------------
    // clock and data share one synchroniser so their relative timing holds
    dfp_sync #(
        .WIDTH(2)
    ) u_sync (
        .core_clk_in(core_clk_in),
        .sys_rst_in(sys_rst_in),
        .async_in({link.debug_link_clock, link.debug_link_data}),
        .sync_out({s_clk, s_data})
    );

    // edges of the host clock, seen in the core domain
    assign rise = s_clk & ~r.clk_prev;
    assign fall = ~s_clk & r.clk_prev;

    // ------------------------------------------------------------
    // frame engine and register file
    // ------------------------------------------------------------
    always_comb begin
        logic [7:0] wbyte;
        logic [7:0] rval;
        logic [1:0] op_new;
        wbyte = {s_data, r.sh[7:1]};
        rval = 8'h00;
        op_new = {s_data, r.op[1]};
        next_r = r;
        next_r.clk_prev = s_clk;
        next_r.erase_all = 1'b0;
        next_r.erase_page = 1'b0;
        next_r.blk_rd = 1'b0;
        next_r.blk_wr = 1'b0;
        next_r.wr_stb = 1'b0;
        next_r.rd_stb = 1'b0;

        // read mux: the link is the only path into these registers
        if (!dfp_pkg::op_is_read(r.op[1:0]) || r.op == dfp_pkg::OP_DATA_READ) begin
            unique case (r.sel)
                dfp_pkg::ADDR_DEVICE_ID: rval = DEVICE_ID;
                dfp_pkg::ADDR_REVISION_ID: rval = REVISION_ID;
                dfp_pkg::ADDR_PROG_CONTROL: rval = r.ctrl;
                dfp_pkg::ADDR_PROG_DATA: rval = (r.unlock == UL_OPEN) ? prog_rd_data_in : 8'h00;
                default: rval = 8'h00;
            endcase
        end
        if (r.op == dfp_pkg::OP_ADDR_READ) begin
            rval = r.sel;
        end

        unique case (r.st)
            DS_IDLE: begin
                // a low data line at a rising clock edge opens a frame
                if (rise && s_data == dfp_pkg::START_LEVEL) begin
                    next_r.st = DS_OP;
                    next_r.cnt = 4'h0;
                end
            end
            DS_OP: begin
                if (rise) begin
                    next_r.op = op_new;
                    next_r.cnt = r.cnt + 4'h1;
                    if (r.cnt == 4'(dfp_pkg::OP_BITS - 1)) begin
                        next_r.cnt = 4'h0;
                        next_r.st = dfp_pkg::op_is_read(op_new) ? DS_TURN : DS_DATA;
                    end
                end
            end
            DS_DATA: begin
                if (rise) begin
                    next_r.sh = wbyte;
                    next_r.cnt = r.cnt + 4'h1;
                    if (r.cnt == 4'(dfp_pkg::BYTE_BITS - 1)) begin
                        next_r.st = DS_IDLE;
                        if (r.op == dfp_pkg::OP_ADDR_WRITE) begin
                            next_r.sel = wbyte;
                        end else begin
                            unique case (r.sel)
                                dfp_pkg::ADDR_PROG_CONTROL: begin
                                    next_r.ctrl = wbyte;
                                    // once open, nothing but reset closes it
                                    if (r.unlock != UL_OPEN) begin
                                        if (r.unlock == UL_FIRST && wbyte == dfp_pkg::UNLOCK_SECOND) begin
                                            next_r.unlock = UL_OPEN;
                                            next_r.cmd_wait = 1'b1;
                                        end else if (wbyte == dfp_pkg::UNLOCK_FIRST) begin
                                            next_r.unlock = UL_FIRST;
                                        end else begin
                                            next_r.unlock = UL_LOCKED;
                                        end
                                    end
                                end
                                dfp_pkg::ADDR_PROG_DATA: begin
                                    // data writes while locked are dropped silently
                                    if (r.unlock == UL_OPEN) begin
                                        next_r.wdata = wbyte;
                                        next_r.wr_stb = 1'b1;
                                        if (r.cmd_wait) begin
                                            next_r.cmd_wait = 1'b0;
                                            unique case (wbyte)
                                                dfp_pkg::CMD_DEVICE_ERASE: next_r.erase_all = 1'b1;
                                                dfp_pkg::CMD_PAGE_ERASE: next_r.erase_page = 1'b1;
                                                dfp_pkg::CMD_BLOCK_READ: next_r.blk_rd = 1'b1;
                                                dfp_pkg::CMD_BLOCK_WRITE: next_r.blk_wr = 1'b1;
                                                default: next_r.cmd_wait = 1'b1;
                                            endcase
                                        end
                                    end
                                end
                                // identifier registers ignore writes
                                default: next_r.sel = r.sel;
                            endcase
                        end
                    end
                end
            end
            DS_TURN: begin
                // host released the line at this falling edge; take it over
                if (fall) begin
                    next_r.drv = rval[0];
                    next_r.sh = rval >> 1;
                    next_r.oe = 1'b1;
                    next_r.cnt = 4'h1;
                    next_r.st = DS_REPLY;
                    next_r.rd_stb = (r.op == dfp_pkg::OP_DATA_READ) &&
                                    (r.sel == dfp_pkg::ADDR_PROG_DATA) && (r.unlock == UL_OPEN);
                end
            end
            DS_REPLY: begin
                if (fall) begin
                    if (r.cnt == 4'(dfp_pkg::BYTE_BITS)) begin
                        next_r.oe = 1'b0;
                        next_r.st = DS_IDLE;
                    end else begin
                        next_r.drv = r.sh[0];
                        next_r.sh = r.sh >> 1;
                        next_r.cnt = r.cnt + 4'h1;
                    end
                end
            end
            default: next_r.st = DS_IDLE;
        endcase

        // re-arm wins over a command taken in the same cycle
        if (cmd_done_in && r.unlock == UL_OPEN) begin
            next_r.cmd_wait = 1'b1;
        end
    end

    // an open unlock state only clears here, by the system reset
    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            r <= '0;
            r.st <= DS_IDLE;
            r.sel <= dfp_pkg::SELECT_RESET;
            r.ctrl <= dfp_pkg::CONTROL_RESET;
            r.unlock <= UL_LOCKED;
        end else begin
            r <= next_r;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign link.dev_data_out = r.drv;
    assign link.dev_data_oe = r.oe;
    assign prog_enabled_out = (r.unlock == UL_OPEN);
    assign flash_control_out = r.ctrl;
    assign device_erase_out = r.erase_all;
    assign page_erase_out = r.erase_page;
    assign block_read_out = r.blk_rd;
    assign block_write_out = r.blk_wr;
    assign prog_data_wr_out = r.wr_stb;
    assign prog_data_out = r.wdata;
    assign prog_data_rd_out = r.rd_stb;
endmodule

// ===== dfp_host.sv
`timescale 1ns/1ns
module dfp_host #(
    parameter int HALF_CYCLES = dfp_pkg::LINK_HALF_CYCLES
) (
    input wire logic core_clk_in,          // core clock, also apb clock
    input wire logic sys_rst_in,           // async reset, active high
    input wire logic psel_in,              // apb select
    input wire logic penable_in,           // apb enable
    input wire logic pwrite_in,            // apb direction
    input wire logic [11:0] paddr_in,      // apb byte address
    input wire logic [31:0] pwdata_in,     // apb write data
    output logic [31:0] prdata_out,        // apb read data
    output logic pready_out,               // apb ready
    output logic pslverr_out,              // apb error on unmapped address
    dfp_link_if.host link                  // debug link pins
);
    // below three core cycles a half period the reply would not settle in time
    if (HALF_CYCLES < 3 || HALF_CYCLES > 255) begin : g_bad_half
        $error("HALF_CYCLES must lie in 3..255");
    end

    typedef struct packed {
        logic busy;
        logic finishing;
        logic [1:0] op;
        logic [7:0] tx;
        logic [7:0] rx;
        logic [7:0] rdata;
        logic [3:0] period;
        logic [7:0] half_cnt;
        logic lclk;
        logic dout;
        logic doe;
        logic [31:0] prdata;
        logic pslverr;
    } dfp_host_state_t;

    dfp_host_state_t r;
    dfp_host_state_t next_r;
    logic s_data;
    logic launch;

    dfp_sync #(
        .WIDTH(1)
    ) u_sync (
        .core_clk_in(core_clk_in),
        .sys_rst_in(sys_rst_in),
        .async_in(link.debug_link_data),
        .sync_out(s_data)
    );

    // a command write while a frame runs is dropped
    assign launch = psel_in & penable_in & pwrite_in & ~r.busy &
                    (paddr_in == dfp_pkg::APB_ADDR_COMMAND);

    // ------------------------------------------------------------
    // apb decode and frame generator
    // ------------------------------------------------------------
    always_comb begin
        next_r = r;

        // read data is prepared in the setup cycle so it comes from a flop
        if (psel_in && !penable_in) begin
            next_r.prdata = 32'h0000_0000;
            next_r.pslverr = 1'b0;
            unique case (paddr_in)
                dfp_pkg::APB_ADDR_COMMAND: next_r.prdata = 32'h0000_0000;
                dfp_pkg::APB_ADDR_STATUS: next_r.prdata[dfp_pkg::STATUS_BUSY_BIT] = r.busy;
                dfp_pkg::APB_ADDR_READ_DATA: next_r.prdata[7:0] = r.rdata;
                default: next_r.pslverr = 1'b1;
            endcase
        end

        // software supplies unlock codes, flash commands and selections verbatim
        if (launch) begin
            next_r.busy = 1'b1;
            next_r.finishing = 1'b0;
            next_r.op = pwdata_in[dfp_pkg::CMD_OP_LSB +: 2];
            next_r.tx = pwdata_in[dfp_pkg::CMD_BYTE_LSB +: 8];
            next_r.period = 4'h0;
            next_r.half_cnt = 8'h00;
            next_r.lclk = 1'b0;
            next_r.dout = dfp_pkg::START_LEVEL;
            next_r.doe = 1'b1;
        end else if (r.busy) begin
            if (r.half_cnt == 8'(HALF_CYCLES - 1)) begin
                next_r.half_cnt = 8'h00;
                if (r.finishing) begin
                    next_r.busy = 1'b0;
                end else if (!r.lclk) begin
                    next_r.lclk = 1'b1;
                end else begin
                    // falling edge: sample reply late in the high half, then move on
                    next_r.lclk = 1'b0;
                    if (dfp_pkg::op_is_read(r.op) &&
                        r.period >= 4'(dfp_pkg::REPLY_FIRST_PERIOD)) begin
                        next_r.rx = {s_data, r.rx[7:1]};
                    end
                    if (r.period == 4'(dfp_pkg::FRAME_PERIODS - 1)) begin
                        next_r.finishing = 1'b1;
                        next_r.doe = 1'b0;
                        next_r.dout = dfp_pkg::LINK_IDLE_LEVEL;
                        if (dfp_pkg::op_is_read(r.op)) begin
                            next_r.rdata = {s_data, r.rx[7:1]};
                        end
                    end else begin
                        next_r.period = r.period + 4'h1;
                        if (r.period < 4'(dfp_pkg::OP_BITS)) begin
                            next_r.dout = r.op[r.period[0]];
                        end else if (!dfp_pkg::op_is_read(r.op)) begin
                            next_r.dout = r.tx[0];
                            next_r.tx = r.tx >> 1;
                        end else begin
                            // turnaround: release so the device can answer
                            next_r.doe = 1'b0;
                            next_r.dout = dfp_pkg::LINK_IDLE_LEVEL;
                        end
                    end
                end
            end else begin
                next_r.half_cnt = r.half_cnt + 8'h01;
            end
        end
    end

    // a system reset of the target is software's job; mode exit needs it
    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            r <= '0;
            r.dout <= dfp_pkg::LINK_IDLE_LEVEL;
        end else begin
            r <= next_r;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign prdata_out = r.prdata;
    assign pready_out = 1'b1;
    assign pslverr_out = r.pslverr;
    assign link.debug_link_clock = r.lclk;
    assign link.host_data_out = r.dout;
    assign link.host_data_oe = r.doe;
endmodule

// ===== dfp_link_if.sv
`timescale 1ns/1ns
interface dfp_link_if;
    logic debug_link_clock;
    logic host_data_out;
    logic host_data_oe;
    logic dev_data_out;
    logic dev_data_oe;
    logic debug_link_data;

    // resolved wire: a weak pull-up holds the line high when nobody drives
    assign debug_link_data = host_data_oe ? host_data_out :
                             (dev_data_oe ? dev_data_out : dfp_pkg::LINK_IDLE_LEVEL);

    modport host (
        output debug_link_clock,
        output host_data_out,
        output host_data_oe,
        input debug_link_data
    );

    modport device (
        input debug_link_clock,
        input debug_link_data,
        output dev_data_out,
        output dev_data_oe
    );
endinterface

// ===== dfp_pkg.sv
package dfp_pkg;

    // ------------------------------------------------------------
    // debug register selections on the far side of the link
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_DEVICE_ID = 8'h00;
    localparam logic [7:0] ADDR_REVISION_ID = 8'h01;
    localparam logic [7:0] ADDR_PROG_CONTROL = 8'h02;
    localparam logic [7:0] ADDR_PROG_DATA = 8'hb4;
    localparam logic [7:0] SELECT_RESET = 8'h00;
    localparam logic [7:0] CONTROL_RESET = 8'h00;

    // unlock codes and flash command bytes
    localparam logic [7:0] UNLOCK_FIRST = 8'h02;
    localparam logic [7:0] UNLOCK_SECOND = 8'h01;
    localparam logic [7:0] CMD_DEVICE_ERASE = 8'h03;
    localparam logic [7:0] CMD_BLOCK_READ = 8'h06;
    localparam logic [7:0] CMD_BLOCK_WRITE = 8'h07;
    localparam logic [7:0] CMD_PAGE_ERASE = 8'h08;

    // ------------------------------------------------------------
    // frame layout: start bit, two op bits lsb first, eight data bits
    // ------------------------------------------------------------
    localparam logic [1:0] OP_ADDR_WRITE = 2'h0;
    localparam logic [1:0] OP_ADDR_READ = 2'h1;
    localparam logic [1:0] OP_DATA_WRITE = 2'h2;
    localparam logic [1:0] OP_DATA_READ = 2'h3;
    localparam int OP_BITS = 2;
    localparam int BYTE_BITS = 8;
    localparam int REPLY_FIRST_PERIOD = 3;
    localparam int FRAME_PERIODS = 11;
    localparam logic START_LEVEL = 1'b0;
    localparam logic LINK_IDLE_LEVEL = 1'b1;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CORE_CLK_PERIOD_NS = 50;
    localparam int LINK_CLK_PERIOD_NS = 400;
    localparam int LINK_HALF_CYCLES = LINK_CLK_PERIOD_NS / (2 * CORE_CLK_PERIOD_NS);

    // ------------------------------------------------------------
    // host controller apb map
    // ------------------------------------------------------------
    localparam logic [11:0] APB_ADDR_COMMAND = 12'h000;
    localparam logic [11:0] APB_ADDR_STATUS = 12'h004;
    localparam logic [11:0] APB_ADDR_READ_DATA = 12'h008;
    localparam int CMD_OP_LSB = 0;
    localparam int CMD_BYTE_LSB = 8;
    localparam int STATUS_BUSY_BIT = 0;

    // read ops carry a one in the low op bit
    function automatic logic op_is_read(input logic [1:0] op);
        return op[0];
    endfunction

endpackage

// ===== dfp_sva.sv
`timescale 1ns/1ns
module dfp_sva (
    input wire logic core_clk_in,      // core clock
    input wire logic sys_rst_in,       // async reset, active high
    input wire logic debug_link_clock, // link clock
    input wire logic host_data_out,    // host data level
    input wire logic host_data_oe,     // host drives
    input wire logic dev_data_out,     // device data level
    input wire logic dev_data_oe,      // device drives
    input wire logic debug_link_data   // resolved wire
);
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (sys_rst_in);
    // ------------------------------------------------------------
    // wire rules, default link timing of four core cycles a half
    // ------------------------------------------------------------
    sequence s_start;
        $rose(host_data_oe) && !host_data_out;
    endsequence
    a_no_clash: assert property (!(host_data_oe && dev_data_oe))
        else $error("both ends drive the data line");
    a_start_low: assert property ($rose(host_data_oe) |-> s_start and !debug_link_clock)
        else $error("frame does not open with a low start bit");
    a_header_len: assert property (s_start |-> ##23 host_data_oe ##[1:66] !host_data_oe)
        else $error("host released the line at the wrong time");
    a_clk_high: assert property ($rose(debug_link_clock) |->
        debug_link_clock [*4] ##1 !debug_link_clock)
        else $error("link clock high half has wrong length");
    a_clk_owned: assert property (debug_link_clock |-> host_data_oe || dev_data_oe)
        else $error("link clock high with nobody driving data");
    a_wire_steady: assert property (debug_link_clock && $past(debug_link_clock) |->
        $stable(debug_link_data))
        else $error("data changed while link clock high");
    a_dev_late: assert property ($rose(dev_data_oe) |-> !debug_link_clock && !$past(host_data_oe))
        else $error("device took the line too early");
    // the host parks its data flop at the idle level whenever it lets go
    a_wire_pull: assert property (!host_data_oe |-> host_data_out && (dev_data_oe || debug_link_data))
        else $error("released line not at idle level");
endmodule

// ===== dfp_sync.sv
`timescale 1ns/1ns
module dfp_sync #(
    parameter int WIDTH = 1
) (
    input wire logic core_clk_in,           // core clock
    input wire logic sys_rst_in,            // async reset, active high
    input wire logic [WIDTH-1:0] async_in,  // pin levels
    output logic [WIDTH-1:0] sync_out       // levels safe to use
);
    if (WIDTH < 1) begin : g_bad_width
        $error("WIDTH must be at least 1");
    end

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } dfp_sync_state_t;

    dfp_sync_state_t r;
    dfp_sync_state_t next_r;

    // the first stage feeds only the second, to let metastability settle
    always_comb begin
        next_r.meta = async_in;
        next_r.stable = r.meta;
    end

    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign sync_out = r.stable;
endmodule

// ===== tb_top.sv
`timescale 1ns/1ns
module tb_top;
    logic core_clk_in = 1'b0, sys_rst_in = 1'b1, psel_in = 1'b0, penable_in = 1'b0;
    logic pwrite_in = 1'b0, cmd_done_in = 1'b0, er, pready_out, pslverr_out, prog_enabled_out;
    logic [11:0] paddr_in = 12'h000;
    logic [31:0] pwdata_in = 32'h0, prdata_out, rd;
    logic [7:0] flash_control_out, prog_data_out, prog_rd_data_in = 8'h00;
    logic [5:0] pv;
    int failures = 0, num_checks = 0, cyc = 0, seed = 72090, cnt[6], em[6];
    int en, stp, sel, ctl, armed, ex;
    localparam logic [7:0] ID_V = 8'h6c;  // arbitrary value
    localparam logic [7:0] REV_V = 8'h21; // arbitrary value
    localparam logic [7:0] CMDS[4] = '{8'h03, 8'h08, 8'h06, 8'h07};
    localparam logic [7:0] UNL[7] = '{8'h01, 8'h02, 8'h05, 8'h01, 8'h02, 8'h02, 8'h01};
    dfp_link_if link ();
    dfp_host i_dfp_host (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in), .psel_in(psel_in),
        .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
        .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
        .pslverr_out(pslverr_out), .link(link.host));
    dfp_device #(.DEVICE_ID(ID_V), .REVISION_ID(REV_V)) i_dfp_device (.core_clk_in(core_clk_in),
        .sys_rst_in(sys_rst_in), .link(link.device), .prog_rd_data_in(prog_rd_data_in),
        .cmd_done_in(cmd_done_in), .prog_enabled_out(prog_enabled_out),
        .flash_control_out(flash_control_out), .device_erase_out(pv[0]),
        .page_erase_out(pv[1]), .block_read_out(pv[2]), .block_write_out(pv[3]),
        .prog_data_wr_out(pv[4]), .prog_data_out(prog_data_out), .prog_data_rd_out(pv[5]));
    dfp_sva i_dfp_sva (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in),
        .debug_link_clock(link.debug_link_clock), .host_data_out(link.host_data_out),
        .host_data_oe(link.host_data_oe), .dev_data_out(link.dev_data_out),
        .dev_data_oe(link.dev_data_oe), .debug_link_data(link.debug_link_data));
    // ------------------------------------------------------------
    // clock, pulse counters and hang guard
    // ------------------------------------------------------------
    initial begin
        forever #25 core_clk_in = ~core_clk_in;
    end
    always @(posedge core_clk_in) begin
        cyc++;
        for (int i = 0; i < 6; i++) if (pv[i] === 1'b1) cnt[i]++;
        if (cyc == 20000) begin
            failures++;
            report_and_stop();
        end
    end
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task report_and_stop;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // model state follows the design through reset too
    task mreset;
        sys_rst_in <= 1'b1;
        repeat (6) @(posedge core_clk_in);
        sys_rst_in <= 1'b0;
        en = 0; stp = 0; sel = 0; ctl = 0; armed = 1;
    endtask
    // one apb transfer; pready is waited for, not assumed
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge core_clk_in);
        psel_in <= 1'b1; penable_in <= 1'b0; pwrite_in <= w; paddr_in <= a; pwdata_in <= d;
        @(posedge core_clk_in);
        penable_in <= 1'b1;
        @(posedge core_clk_in);
        while (pready_out !== 1'b1) @(posedge core_clk_in);
        rd = prdata_out;
        er = pslverr_out;
        psel_in <= 1'b0; penable_in <= 1'b0;
    endtask
    // one link frame, then the model predicts what it changed
    task lop(input logic [1:0] op, input logic [7:0] b);
        int n;
        apb(1'b1, dfp_pkg::APB_ADDR_COMMAND, {16'h0, b, 6'h0, op});
        n = 0;
        do begin
            apb(1'b0, dfp_pkg::APB_ADDR_STATUS, 32'h0);
            n++;
        end while (rd[0] !== 1'b0 && n < 300);
        chk(32'(rd[0]), 32'h0);
        apb(1'b0, dfp_pkg::APB_ADDR_READ_DATA, 32'h0);
        ex = sel == 0 ? ID_V : sel == 1 ? REV_V : sel == 2 ? ctl : 0;
        if (sel == 8'hb4 && en) ex = prog_rd_data_in;
        if (op == 2'h0) sel = b;
        if (op == 2'h3 && sel == 8'hb4 && en) em[5]++;
        if (op == 2'h2 && sel == 2) begin
            ctl = b;
            en = en || (stp && b == 8'h01);
            stp = b == 8'h02;
        end
        if (op == 2'h2 && sel == 8'hb4 && en) begin
            em[4]++;
            chk(32'(prog_data_out), 32'(b));
            for (int i = 0; i < 4; i++) if (armed && b == CMDS[i]) begin
                em[i]++;
                armed = 0;
            end
        end
        if (op[0]) chk(32'(rd[7:0]), op[1] ? ex : sel);
        chk(32'(prog_enabled_out), en);
        chk(32'(flash_control_out), ctl);
        for (int i = 0; i < 6; i++) chk(cnt[i], em[i]);
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        mreset();
        chk(32'(flash_control_out), 32'h0);
        apb(1'b0, 12'h010, 32'h0);
        chk(32'(er), 32'h1);
        lop(2'h1, 8'h00);
        lop(2'h0, 8'h00);
        lop(2'h2, 8'($random(seed)));
        lop(2'h3, 8'h00);
        lop(2'h0, 8'h01);
        lop(2'h2, 8'($random(seed)));
        lop(2'h3, 8'h00);
        lop(2'h0, 8'hb4);
        lop(2'h2, 8'h03);
        lop(2'h3, 8'h00);
        lop(2'h0, 8'h02);
        for (int i = 0; i < 7; i++) lop(2'h2, UNL[i]);
        lop(2'h2, 8'h00);
        lop(2'h0, 8'hb4);
        for (int i = 0; i < 4; i++) begin
            @(posedge core_clk_in) cmd_done_in <= 1'b1;
            @(posedge core_clk_in) cmd_done_in <= 1'b0;
            armed = 1;
            lop(2'h2, CMDS[i]);
            lop(2'h2, 8'($random(seed)));
        end
        prog_rd_data_in <= 8'($random(seed));
        lop(2'h3, 8'h00);
        mreset();
        lop(2'h0, 8'h02);
        lop(2'h3, 8'h00);
        report_and_stop();
    end
endmodule
